// ==== testbench.sv ====
// Self-checking bench for ubr_top over AXI4-Lite.
// Assumes the 25 MHz clock and the offsets of ubr_pkg.
`timescale 1ns/10ps
module testbench;
  import ubr_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, rx = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, rx_level, baud_tick;
  logic [1:0] bresp, rresp, r;
  int err_total = 0, checks_done = 0, c;
  int per [8] = '{192, 48, 4144, 1036, 12, 12, 1036, 1036};
  always #20 aclk = ~aclk;
  ubr_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx(rx),
    .rx_level(rx_level), .baud_tick(baud_tick));
  // ====
  // Checks and closing
  task automatic cv(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ====
  // Bus tasks; answers are sampled mid-cycle, where they are settled
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [3:0] s);
    int n;
    logic aw, w, b;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) break;
    end
    bready <= 1'b0;
    if (n == 50) err_total++;
    if (n == 50) wrap_up;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    int n;
    logic ar, b;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ar = arvalid && arready;
      b = rvalid;
      v = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar) arvalid <= 1'b0;
      if (b) break;
    end
    rready <= 1'b0;
    if (n == 50) err_total++;
    if (n == 50) wrap_up;
  endtask
  task automatic wait_tick(output int k);
    for (k = 1; k < 9000; k++) begin
      @(negedge aclk);
      if (baud_tick === 1'b1) break;
    end
    if (k == 9000) err_total++;
    if (k == 9000) wrap_up;
  endtask
  // ====
  // Tests
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(8'(4 * i), d);
      cv("reset value", (i == 5) ? 32'h1 : 32'h0, d);
    end
    wr(ubr_off_bc, 8'hFF, 4'hF);
    wr(ubr_off_bc, 8'h00, 4'h0);
    rd(ubr_off_bc, d);
    cv("baud control", 32'hFB, d);
    wr(8'h18, 8'h55, 4'hF);
    cv("bad write", ubr_resp_slverr, r);
    rd(8'h18, d);
    cv("bad read resp", ubr_resp_slverr, r);
    cv("bad read data", 32'h0, d);
    $display("registers done");
    wr(ubr_off_div_hi, 8'h01, 4'hF);
    // Index bits are sync, wide and high speed
    for (int i = 0; i < 8; i++) begin
      wr(ubr_off_tsc, {3'h0, i[2], 1'b0, i[0], 2'h0}, 4'hF);
      wr(ubr_off_bc, {4'h0, i[1], 3'h0}, 4'hF);
      wr(ubr_off_div_lo, 8'h02, 4'hF);
      wait_tick(c);
      wait_tick(c);
      cv("tick period", per[i], c);
    end
    $display("modes done");
    wr(ubr_off_tsc, 8'h00, 4'hF);
    wr(ubr_off_bc, 8'h00, 4'hF);
    wait_tick(c);
    repeat (100) @(posedge aclk);
    wr(ubr_off_div_lo, 8'h02, 4'hF);
    wait_tick(c);
    cv("restart", 1, c > 189 && c < 195);
    $display("restart done");
    rx <= 1'b0;
    @(posedge aclk);
    rx <= 1'b1;
    repeat (6) begin
      @(negedge aclk);
      cv("glitch", 1, rx_level);
    end
    @(posedge aclk);
    rx <= 1'b0;
    repeat (8) @(posedge aclk);
    rd(ubr_off_status, d);
    cv("rx level", 32'h0, d);
    $display("sampling done");
    wrap_up;
  end
endmodule  // testbench
bind ubr_top ubr_props u_props (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .rx, .rx_level, .baud_tick);

// ==== ubr_pkg.sv ====
// Constants shared by the rate generator and its register front end.
// Assumes a single 25 MHz clock and byte-wide registers on word offsets.
package ubr_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] ubr_off_tsc = 8'h00;
  localparam logic [7:0] ubr_off_rsc = 8'h04;
  localparam logic [7:0] ubr_off_bc = 8'h08;
  localparam logic [7:0] ubr_off_div_lo = 8'h0C;
  localparam logic [7:0] ubr_off_div_hi = 8'h10;
  localparam logic [7:0] ubr_off_status = 8'h14;
  // ==========================================================
  // Field positions
  localparam int ubr_bit_sync = 4;
  localparam int ubr_bit_high_speed = 2;
  localparam int ubr_bit_wide = 3;
  localparam int ubr_bit_bc_unimpl = 2;
  localparam int ubr_bit_rx_level = 0;
  // ==========================================================
  // Reset values
  localparam logic [7:0] ubr_rst_tsc = 8'h00;
  localparam logic [7:0] ubr_rst_rsc = 8'h00;
  localparam logic [7:0] ubr_rst_bc = 8'h00;
  localparam logic [7:0] ubr_rst_div = 8'h00;
  // ==========================================================
  // Prescale factors and bus answers
  localparam logic [6:0] ubr_pre_64 = 7'h40;
  localparam logic [6:0] ubr_pre_16 = 7'h10;
  localparam logic [6:0] ubr_pre_4 = 7'h04;
  localparam logic [1:0] ubr_resp_okay = 2'h0;
  localparam logic [1:0] ubr_resp_slverr = 2'h2;
endpackage

// ==== ubr_props.sv ====
// Checker for ubr_top, attached by bind.
// Assumes aresetn is synchronous to aclk and active low.
`timescale 1ns/10ps
module ubr_props
  import ubr_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial side
  input wire logic rx,
  input wire logic rx_level,
  input wire logic baud_tick
);
  // ====
  // Properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_w_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  // Shortest period is four cycles, so a tick never repeats sooner
  a_tick_gap: assert property (baud_tick |=> !baud_tick [*3])
    else $error("tick period too short");
  a_vote_high: assert property (rx [*6] |-> rx_level)
    else $error("rx level not high");
  a_vote_low: assert property (!rx [*6] |-> !rx_level)
    else $error("rx level not low");
  c_tick: cover property (baud_tick);
  c_bad_write: cover property (s_axi_bvalid && s_axi_bresp == ubr_resp_slverr);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule  // ubr_props

// ==== ubr_rate_gen.sv ====
// Free running rate timer: prescaler then divisor counter.
// Assumes the clock is the device clock and clear is a one-cycle pulse.
`timescale 1ns/10ps
module ubr_rate_gen (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Settings and tick
  ubr_rate_if.gen rate
);
  import ubr_pkg::*;

  logic [6:0] pre_count;
  logic [15:0] div_count;
  logic [6:0] factor;
  logic [15:0] n_eff;
  logic pre_wrap;
  logic tick_q;

  // ==========================================================
  // Mode decode
  always_comb begin
    if (rate.sync_mode) begin
      factor = ubr_pre_4;
    end else if (rate.wide_divisor_sel && rate.high_speed_sel) begin
      factor = ubr_pre_4;
    end else if (rate.wide_divisor_sel || rate.high_speed_sel) begin
      factor = ubr_pre_16;
    end else begin
      factor = ubr_pre_64;
    end
  end

  // Narrow mode ignores the high byte
  assign n_eff = rate.wide_divisor_sel ? rate.divisor : {8'h00, rate.divisor[7:0]};
  // A mode change to a smaller factor wraps at once instead of running to 127
  assign pre_wrap = (pre_count >= factor - 7'h01);

  // ==========================================================
  // Counters, all on the device clock so the rate follows it
  always_ff @(posedge aclk) begin
    if (!aresetn || rate.clear) begin
      pre_count <= 7'h00;
    end else if (pre_wrap) begin
      pre_count <= 7'h00;
    end else begin
      pre_count <= pre_count + 7'h01;
    end
  end

  // Compare with >= so a divisor lowered mid-count cannot run away
  always_ff @(posedge aclk) begin
    if (!aresetn || rate.clear) begin
      div_count <= 16'h0000;
      tick_q <= 1'b0;
    end else if (pre_wrap && div_count >= n_eff) begin
      div_count <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      if (pre_wrap) begin
        div_count <= div_count + 16'h0001;
      end
      tick_q <= 1'b0;
    end
  end

  assign rate.tick = tick_q;
endmodule // ubr_rate_gen

// ==== ubr_rate_if.sv ====
// Carrier between the register front end and the rate generator.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface ubr_rate_if;
  logic [15:0] divisor;
  logic sync_mode;
  logic high_speed_sel;
  logic wide_divisor_sel;
  logic clear;
  logic tick;
  modport gen (input divisor, input sync_mode, input high_speed_sel, input wide_divisor_sel,
               input clear, output tick);
  modport ctl (output divisor, output sync_mode, output high_speed_sel, output wide_divisor_sel,
               output clear, input tick);
endinterface

// ==== ubr_top.sv ====
// Rate generator with AXI4-Lite registers and majority sampling of rx.
// Assumes rx is already synchronous to aclk and one AXI master.
//
// Behaviour
// - Bit rate derives from the device clock and follows its frequency.
// - Receive level is a majority vote of three samples.
// - Divisor n is high byte concatenated above low byte.
// - Async, narrow, normal speed: clock over 64 times n plus one.
// - Async, narrow, high speed: clock over 16 times n plus one.
// - Async, wide, normal speed: clock over 16 times n plus one.
// - Sync, narrow: clock over 4 times n plus one; speed select ignored.
// - Sync select at bit 4, high speed at bit 2 of transmit control.
// - Wide divisor select at bit 3 of baud control.
// - Narrow divisor after reset; wide select enables 16-bit divisor.
// - Writing either divisor byte clears the rate timer at once.
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/10ps
module ubr_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial side
  input wire logic rx,
  output logic rx_level,
  output logic baud_tick
);
  import ubr_pkg::*;

  function automatic logic majority3(input logic [2:0] s);
    majority3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ubr_off_tsc) || (a == ubr_off_rsc) || (a == ubr_off_bc) ||
             (a == ubr_off_div_lo) || (a == ubr_off_div_hi) || (a == ubr_off_status);
  endfunction

  ubr_rate_if rate_bus ();

  logic [7:0] transmit_status_control;
  logic [7:0] receive_status_control;
  logic [7:0] baud_control;
  logic [7:0] divisor_high_byte;
  logic [7:0] divisor_low_byte;
  logic [7:0] aw_addr;
  logic aw_held;
  logic [7:0] w_data;
  logic w_lane0;
  logic w_held;
  logic do_write;
  logic [2:0] rx_samples;
  logic rx_vote;
  logic tick_q;
  logic [31:0] next_rdata;

  // ==========================================================
  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ubr_resp_okay;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(aw_addr) ? ubr_resp_okay : ubr_resp_slverr;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Registers; only byte lane 0 carries data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      transmit_status_control <= ubr_rst_tsc;
      receive_status_control <= ubr_rst_rsc;
      baud_control <= ubr_rst_bc;
    end else if (do_write && w_lane0) begin
      if (aw_addr == ubr_off_tsc) begin
        transmit_status_control <= w_data;
      end
      if (aw_addr == ubr_off_rsc) begin
        receive_status_control <= w_data;
      end
      if (aw_addr == ubr_off_bc) begin
        baud_control <= w_data & ~(8'h01 << ubr_bit_bc_unimpl);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      divisor_high_byte <= ubr_rst_div;
      divisor_low_byte <= ubr_rst_div;
    end else if (do_write && w_lane0) begin
      if (aw_addr == ubr_off_div_hi) begin
        divisor_high_byte <= w_data;
      end
      if (aw_addr == ubr_off_div_lo) begin
        divisor_low_byte <= w_data;
      end
    end
  end

  // Timer clear lands with the new value, so the first period is full length
  assign rate_bus.clear = do_write && w_lane0 &&
                          (aw_addr == ubr_off_div_hi || aw_addr == ubr_off_div_lo);
  assign rate_bus.divisor = {divisor_high_byte, divisor_low_byte};
  assign rate_bus.sync_mode = transmit_status_control[ubr_bit_sync];
  assign rate_bus.high_speed_sel = transmit_status_control[ubr_bit_high_speed];
  assign rate_bus.wide_divisor_sel = baud_control[ubr_bit_wide];

  ubr_rate_gen u_rate_gen (
    .aclk(aclk),
    .aresetn(aresetn),
    .rate(rate_bus)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= rate_bus.tick;
    end
  end
  assign baud_tick = tick_q;

  // ==========================================================
  // Majority detect over the last three samples filters single-cycle glitches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_samples <= 3'h7;
      rx_vote <= 1'b1;
    end else begin
      rx_samples <= {rx_samples[1:0], rx};
      rx_vote <= majority3(rx_samples);
    end
  end
  assign rx_level = rx_vote;

  // ==========================================================
  // Read channel: answer one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (s_axi_araddr)
      ubr_off_tsc: next_rdata[7:0] = transmit_status_control;
      ubr_off_rsc: next_rdata[7:0] = receive_status_control;
      ubr_off_bc: next_rdata[7:0] = baud_control;
      ubr_off_div_lo: next_rdata[7:0] = divisor_low_byte;
      ubr_off_div_hi: next_rdata[7:0] = divisor_high_byte;
      ubr_off_status: next_rdata[ubr_bit_rx_level] = rx_vote;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ubr_resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= mapped(s_axi_araddr) ? ubr_resp_okay : ubr_resp_slverr;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // ubr_top
